// ==== rtl/fls_cfg.svh ====
`ifndef FLS_CFG_SVH
`define FLS_CFG_SVH

// Core clock rate in MHz; busy times in microseconds are scaled by it.
`define FLS_CLK_MHZ        100

// Instruction codes; the values are arbitrary.
`define FLS_ARM_WRITE_CMD    8'h06
`define FLS_DISARM_WRITE_CMD 8'h04
`define FLS_STATUS_READ_CMD  8'h05
`define FLS_STATUS_WRITE_CMD 8'h01
`define FLS_DATA_READ_CMD    8'h03
`define FLS_PAGE_WRITE_CMD   8'h02
`define FLS_BLOCK_WIPE_CMD   8'hd8
`define FLS_CHIP_WIPE_CMD    8'hc7

// Field positions inside flash_status.
`define FLS_SR_BUSY_BIT    0
`define FLS_SR_LATCH_BIT   1
`define FLS_SR_LEVEL_LO    2
`define FLS_SR_LEVEL_HI    4
`define FLS_SR_LOCK_BIT    7

// Reset values of the protection level and the lock bit.
`define FLS_LEVEL_RESET    3'h0
`define FLS_LOCK_RESET     1'h0

// Array geometry: 128 sectors of 256 pages of 256 bytes.
`define FLS_ADDR_W         23
`define FLS_SECTORS        8'h80
`define FLS_FIFO_DEPTH     4

// Least byte counts of a frame for page write, sector wipe and status write.
`define FLS_PAGE_MIN_BYTES 3'h5
`define FLS_WIPE_MIN_BYTES 3'h4
`define FLS_SR_MIN_BYTES   3'h2

// Default busy times in microseconds.
`define FLS_STATUS_US      15
`define FLS_PAGE_US        1500
`define FLS_SECTOR_US      100000
`define FLS_BULK_US        1000000

`endif

// ==== rtl/fls_pkg.sv ====
package fls_pkg;

  // Frame phase, Gray coded along command, address, data.
  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11,
    PH_IGN  = 2'b10
  } fls_phase_t;

  // Operation codes handed to the array.
  typedef enum logic [1:0] {
    OP_PROG  = 2'b00,
    OP_SECT  = 2'b01,
    OP_BULK  = 2'b11,
    OP_ABORT = 2'b10
  } fls_op_t;

endpackage : fls_pkg

// ==== rtl/fls_stream_if.sv ====
`timescale 1ns/100ps
`default_nettype none

// Byte stream from the serial front end into the program FIFO.
interface fls_stream_if #(parameter int W = 31);
  logic         valid;  // Source holds a word.
  logic         ready;  // Sink can take a word.
  logic [W-1:0] data;   // Address and data of one staged byte.
  logic         idle;   // Sink holds nothing at all.
  modport src (output valid, output data, input ready, input idle);
  modport snk (input valid, input data, output ready, output idle);
endinterface : fls_stream_if

`default_nettype wire

// ==== rtl/fls_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none

// Small FIFO with a registered output word.
module fls_fifo #(
  parameter int W     = 31,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         srst,
  fls_stream_if.snk         in_s,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];           // Storage words.
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d; // Write and read pointers.
  logic [PW:0]   cnt_q, cnt_d;           // Words in storage.
  logic          ov_q, ov_d;             // Output word valid.
  logic [W-1:0]  od_q, od_d;             // Output word.
  logic          push, pop;

  // Storage refuses only when truly full, so back-pressure is honest.
  assign in_s.ready = (cnt_q != (PW+1)'(DEPTH));
  assign in_s.idle  = (cnt_q == '0) && !ov_q;
  assign out_valid  = ov_q;
  assign out_data   = od_q;

  // Pointer and output stage next values.
  always_comb begin
    push = in_s.valid && in_s.ready;
    pop  = (cnt_q != '0) && (!ov_q || out_ready);
    wp_d = push ? PW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? PW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    ov_d = ov_q;
    od_d = od_q;
    if (pop) begin
      ov_d = 1'b1;
      od_d = mem_q[rp_q];
    end else if (out_ready) begin
      ov_d = 1'b0;
    end
  end

  // Registers; storage words need no reset.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
    if (srst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end
endmodule : fls_fifo

`default_nettype wire

// ==== rtl/fls_spi_target.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fls_cfg.svh"

// Functional notes
// - Output bit changes after serial clock falls.
// - Input bit sampled on serial clock rise.
// - Deselected means output not driven.
// - Standby only once internal cycle finished.
// - Nothing accepted before first select falling edge.
// - Hold pauses, sequence resumes unchanged.
// - Held: output released, clock and input ignored.
// - Write protect pin freezes protection settings while lock is set.
// - Modes 0 and 3 both work.
// - Page write, consecutive bytes within one page.
// - Arm, then four bytes plus data, then cycle.
// - Sector or whole array erase, then cycle.
// - Busy flag set during internal cycles.
// - Latch flag shows internal write latch.
// - Three level bits select protected region.
// - Lock plus low protect pin freezes bits.
// - 128 sectors, 256 pages, 256 bytes.
// - Latch cleared at reset and after writes.
// - Writes need bit count multiple of eight.
// - Whole erase only with level zero.
// - Level doubles protected top sector count.
module fls_spi_target #(
  parameter int unsigned STATUS_US = `FLS_STATUS_US,
  parameter int unsigned PAGE_US   = `FLS_PAGE_US,
  parameter int unsigned SECTOR_US = `FLS_SECTOR_US,
  parameter int unsigned BULK_US   = `FLS_BULK_US
) (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_mosi,
  input  wire logic                   spi_hold_n,
  input  wire logic                   spi_wp_n,
  output var  logic                   spi_miso,
  output var  logic                   spi_miso_oe,
  output var  logic [`FLS_ADDR_W-1:0] arr_rd_addr,
  input  wire logic [7:0]             arr_rd_data,
  output var  logic                   arr_wr_valid,
  input  wire logic                   arr_wr_ready,
  output var  logic [`FLS_ADDR_W-1:0] arr_wr_addr,
  output var  logic [7:0]             arr_wr_data,
  output var  logic                   arr_op_valid,
  output var  logic [1:0]             arr_op_code,
  output var  logic [`FLS_ADDR_W-1:0] arr_op_addr,
  output var  logic                   standby
);
  localparam int AW = `FLS_ADDR_W;
  localparam int SW = AW + 8;
  // Busy times converted to core clock cycles.
  localparam int unsigned STATUS_CYC = STATUS_US * `FLS_CLK_MHZ;
  localparam int unsigned PAGE_CYC   = PAGE_US * `FLS_CLK_MHZ;
  localparam int unsigned SECTOR_CYC = SECTOR_US * `FLS_CLK_MHZ;
  localparam int unsigned BULK_CYC   = BULK_US * `FLS_CLK_MHZ;

  // Pin synchroniser order: sclk, cs_n, mosi, hold_n, wp_n.
  logic [4:0] s1_q, s2_q;          // Two flip-flop chain.
  logic       sclk_prev_q;         // Last synchronised clock level.
  logic       cs_prev_q;           // Last synchronised select level.
  logic       sclk, cs_n, mosi, hold_n, wp_n;
  logic       rise, fall, cs_fall, cs_rise;

  fls_pkg::fls_phase_t phase_q, phase_d;  // Frame phase.
  logic          seen_q, seen_d;        // First select edge seen.
  logic          hold_q, hold_d;        // Hold condition active.
  logic [2:0]    bit_q, bit_d;          // Bit within byte.
  logic [2:0]    byte_q, byte_d;        // Whole bytes, saturating.
  logic [7:0]    sh_q, sh_d;            // Input shifter.
  logic [7:0]    cmd_q, cmd_d;          // Instruction of this frame.
  logic [AW-1:0] addr_q, addr_d;        // Frame address.
  logic [7:0]    srn_q, srn_d;          // New status byte.
  logic [7:0]    tx_q, tx_d;            // Output shifter.
  logic          miso_q, miso_d;
  logic          oe_q, oe_d;
  logic          wel_q, wel_d;          // Write latch.
  logic [2:0]    lvl_q, lvl_d;          // Protection level.
  logic          lock_q, lock_d;        // Status lock.
  logic          busy_q, busy_d;        // Internal cycle running.
  logic [31:0]   cnt_q, cnt_d;          // Busy timer.
  logic          pv_q, pv_d;            // Staged byte waiting for FIFO.
  logic [SW-1:0] pd_q, pd_d;
  logic          opp_q, opp_d;          // Array operation waiting.
  logic [1:0]    opc_q, opc_d;
  logic          opv_q, opv_d;
  logic [AW-1:0] rda_q, rda_d;          // Array read address.
  logic          sb_q, sb_d;            // Standby power state.
  logic [7:0]    nsh, src, status, thr;
  logic          prot, frozen;

  fls_stream_if #(.W(SW)) stg ();

  // Program bytes queue here; the array drains them at its own pace.
  fls_fifo #(.W(SW), .DEPTH(`FLS_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_s      (stg.snk),
    .out_valid (arr_wr_valid),
    .out_ready (arr_wr_ready),
    .out_data  ({arr_wr_addr, arr_wr_data})
  );

  assign stg.valid   = pv_q;
  assign stg.data    = pd_q;
  assign spi_miso    = miso_q;
  assign spi_miso_oe = oe_q;
  assign arr_rd_addr = rda_q;
  assign arr_op_valid = opv_q;
  assign arr_op_code = opc_q;
  assign arr_op_addr = addr_q;
  assign standby     = sb_q;

  // Pins come from another domain; only the second stage is read.
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_q        <= 5'h1a;
      s2_q        <= 5'h1a;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      s1_q        <= {spi_wp_n, spi_hold_n, spi_mosi, spi_cs_n, spi_sclk};
      s2_q        <= s1_q;
      sclk_prev_q <= s2_q[0];
      cs_prev_q   <= s2_q[1];
    end
  end

  always_comb begin
    {wp_n, hold_n, mosi, cs_n, sclk} = s2_q;
    // Only edges in a selected, unheld frame count.
    rise    = sclk && !sclk_prev_q && !cs_n && seen_q && !hold_q;
    fall    = !sclk && sclk_prev_q && !cs_n && seen_q && !hold_q;
    cs_fall = !cs_n && cs_prev_q;
    cs_rise = cs_n && !cs_prev_q && seen_q;
  end

  // Status byte and protection decode.
  always_comb begin
    status = 8'h00;
    status[`FLS_SR_BUSY_BIT]  = busy_q;
    status[`FLS_SR_LATCH_BIT] = wel_q;
    status[`FLS_SR_LEVEL_HI:`FLS_SR_LEVEL_LO] = lvl_q;
    status[`FLS_SR_LOCK_BIT] = lock_q;
    // Level n above 0 protects the top 2^n sectors; level 7 covers all 128.
    thr  = `FLS_SECTORS - (8'h01 << lvl_q);
    prot = (lvl_q != 3'h0) && ({1'b0, addr_q[AW-1:16]} >= thr);
    frozen = lock_q && !wp_n;
    nsh = {sh_q[6:0], mosi};
  end

  // Frame, status and busy next values.
  always_comb begin
    phase_d = phase_q; seen_d = seen_q; hold_d = hold_q;
    bit_d = bit_q; byte_d = byte_q; sh_d = sh_q; cmd_d = cmd_q;
    addr_d = addr_q; srn_d = srn_q; tx_d = tx_q; miso_d = miso_q;
    wel_d = wel_q; lvl_d = lvl_q; lock_d = lock_q; busy_d = busy_q;
    cnt_d = cnt_q; pv_d = pv_q; pd_d = pd_q; opp_d = opp_q;
    opc_d = opc_q; opv_d = 1'b0; rda_d = rda_q;
    src = (cmd_q == `FLS_DATA_READ_CMD) ? arr_rd_data : status;
    if (cs_fall) begin
      seen_d = 1'b1;
    end
    // Hold clears on deselect; while selected it changes only while the serial clock is low.
    if (cs_n) begin
      hold_d = 1'b0;
    end else if (!sclk) begin
      hold_d = !hold_n;
    end
    // Driven only while selected and not held.
    oe_d = !cs_n && seen_q && !hold_q;
    if (pv_q && stg.ready) begin
      pv_d = 1'b0;
    end
    if (rise) begin
      sh_d  = nsh;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        byte_d = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
        unique case (phase_q)
          fls_pkg::PH_CMD: begin
            cmd_d = nsh;
            if (busy_q && nsh != `FLS_STATUS_READ_CMD) begin
              phase_d = fls_pkg::PH_IGN;
            end else if (nsh == `FLS_DATA_READ_CMD || nsh == `FLS_PAGE_WRITE_CMD ||
                         nsh == `FLS_BLOCK_WIPE_CMD) begin
              phase_d = fls_pkg::PH_ADDR;
            end else if (nsh == `FLS_STATUS_READ_CMD || nsh == `FLS_STATUS_WRITE_CMD) begin
              phase_d = fls_pkg::PH_DATA;
            end else begin
              phase_d = fls_pkg::PH_IGN;
            end
          end
          fls_pkg::PH_ADDR: begin
            addr_d = {addr_q[AW-9:0], nsh};
            if (byte_q == 3'h3) begin
              phase_d = fls_pkg::PH_DATA;
              rda_d   = {addr_q[AW-9:0], nsh};
            end
          end
          fls_pkg::PH_DATA: begin
            if (cmd_q == `FLS_PAGE_WRITE_CMD) begin
              // Bytes stay inside the page; the column wraps.
              pd_d = {addr_q, nsh};
              pv_d = 1'b1;
              addr_d = {addr_q[AW-1:8], addr_q[7:0] + 8'h01};
            end else if (cmd_q == `FLS_STATUS_WRITE_CMD && byte_q == 3'h1) begin
              srn_d = nsh;
            end
          end
          fls_pkg::PH_IGN: begin
          end
        endcase
      end
    end
    // Load a fresh byte at each byte boundary, else shift.
    if (fall && phase_q == fls_pkg::PH_DATA) begin
      if (bit_q == 3'h0) begin
        miso_d = src[7];
        tx_d   = {src[6:0], 1'b0};
        if (cmd_q == `FLS_DATA_READ_CMD) begin
          rda_d = rda_q + AW'(1);
        end
      end else begin
        miso_d = tx_q[7];
        tx_d   = {tx_q[6:0], 1'b0};
      end
    end
    // An operation leaves once the queue has drained; an abort has no busy cycle to wait in.
    if (opp_q && !pv_q && stg.idle) begin
      opp_d = 1'b0;
      opv_d = 1'b1;
    end
    // Busy timer; a program also waits for the queue to drain.
    if (busy_q) begin
      if (cnt_q != 32'h0) begin
        cnt_d = cnt_q - 32'h1;
      end else if (!opp_q && !pv_q && stg.idle) begin
        busy_d = 1'b0;
        wel_d  = 1'b0;
      end
    end
    // Frame end: instructions act only on whole bytes.
    if (cs_rise) begin
      phase_d = fls_pkg::PH_CMD;
      bit_d   = 3'h0;
      byte_d  = 3'h0;
      if (bit_q == 3'h0 && !busy_q) begin
        if (cmd_q == `FLS_ARM_WRITE_CMD && byte_q != 3'h0) begin
          wel_d = 1'b1;
        end else if (cmd_q == `FLS_DISARM_WRITE_CMD && byte_q != 3'h0) begin
          wel_d = 1'b0;
        end else if (cmd_q == `FLS_PAGE_WRITE_CMD && byte_q >= `FLS_PAGE_MIN_BYTES) begin
          opp_d = 1'b1;
          if (wel_q && !prot) begin
            opc_d  = fls_pkg::OP_PROG;
            busy_d = 1'b1;
            cnt_d  = 32'(PAGE_CYC);
          end else begin
            opc_d = fls_pkg::OP_ABORT;
          end
        end else if (cmd_q == `FLS_BLOCK_WIPE_CMD && byte_q >= `FLS_WIPE_MIN_BYTES &&
                     wel_q && !prot) begin
          opp_d  = 1'b1;
          opc_d  = fls_pkg::OP_SECT;
          busy_d = 1'b1;
          cnt_d  = 32'(SECTOR_CYC);
        end else if (cmd_q == `FLS_CHIP_WIPE_CMD && byte_q != 3'h0 && wel_q &&
                     lvl_q == 3'h0) begin
          opp_d  = 1'b1;
          opc_d  = fls_pkg::OP_BULK;
          busy_d = 1'b1;
          cnt_d  = 32'(BULK_CYC);
        end else if (cmd_q == `FLS_STATUS_WRITE_CMD && byte_q >= `FLS_SR_MIN_BYTES &&
                     wel_q && !frozen) begin
          lvl_d  = srn_q[`FLS_SR_LEVEL_HI:`FLS_SR_LEVEL_LO];
          lock_d = srn_q[`FLS_SR_LOCK_BIT];
          busy_d = 1'b1;
          cnt_d  = 32'(STATUS_CYC);
        end
      end else if (!busy_q && cmd_q == `FLS_PAGE_WRITE_CMD && byte_q >= `FLS_PAGE_MIN_BYTES) begin
        // A ragged page write still leaves staged bytes that must be thrown away.
        opp_d = 1'b1;
        opc_d = fls_pkg::OP_ABORT;
      end
    end
    // Standby waits for any running cycle and for staged bytes to leave.
    sb_d = cs_n && !busy_d && !opp_d;
  end

  // Register stage; no pin value is loaded under reset.
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_q <= fls_pkg::PH_CMD; seen_q <= 1'b0; hold_q <= 1'b0;
      bit_q <= 3'h0; byte_q <= 3'h0; sh_q <= 8'h00; cmd_q <= 8'h00;
      addr_q <= '0; srn_q <= 8'h00; tx_q <= 8'h00; miso_q <= 1'b0;
      oe_q <= 1'b0; wel_q <= 1'b0; lvl_q <= `FLS_LEVEL_RESET;
      lock_q <= `FLS_LOCK_RESET; busy_q <= 1'b0; cnt_q <= 32'h0;
      pv_q <= 1'b0; pd_q <= '0; opp_q <= 1'b0; opc_q <= 2'h0;
      opv_q <= 1'b0; rda_q <= '0; sb_q <= 1'b1;
    end else begin
      phase_q <= phase_d; seen_q <= seen_d; hold_q <= hold_d;
      bit_q <= bit_d; byte_q <= byte_d; sh_q <= sh_d; cmd_q <= cmd_d;
      addr_q <= addr_d; srn_q <= srn_d; tx_q <= tx_d; miso_q <= miso_d;
      oe_q <= oe_d; wel_q <= wel_d; lvl_q <= lvl_d;
      lock_q <= lock_d; busy_q <= busy_d; cnt_q <= cnt_d;
      pv_q <= pv_d; pd_q <= pd_d; opp_q <= opp_d; opc_q <= opc_d;
      opv_q <= opv_d; rda_q <= rda_d; sb_q <= sb_d;
    end
  end
endmodule : fls_spi_target

`default_nettype wire

// ==== tb/fls_spi_target_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fls_cfg.svh"

// Watches the serial pins and the array side of the target.
module fls_target_checks (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic                   spi_sclk,
  input wire logic                   spi_cs_n,
  input wire logic                   spi_hold_n,
  input wire logic                   spi_miso,
  input wire logic                   spi_miso_oe,
  input wire logic                   arr_wr_valid,
  input wire logic                   arr_wr_ready,
  input wire logic [`FLS_ADDR_W-1:0] arr_wr_addr,
  input wire logic [7:0]             arr_wr_data,
  input wire logic                   arr_op_valid,
  input wire logic                   standby
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic [14:0] page_q;  // Page of the last byte taken.
  logic        seen_q;  // A byte was taken since the last operation.

  // Remember the page of each taken byte, so a burst that strays is caught.
  always_ff @(posedge clock) begin
    if (arr_wr_valid && arr_wr_ready) begin
      page_q <= arr_wr_addr[22:8];
    end
    if (srst || arr_op_valid) begin
      seen_q <= 1'b0;
    end else if (arr_wr_valid && arr_wr_ready) begin
      seen_q <= 1'b1;
    end
  end

  a_miso_on_fall: assert property (
    $changed(spi_miso) && !spi_cs_n |-> !spi_sclk)
    else $error("data out moved while serial clock high");
  a_desel_released: assert property (
    spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("data out driven while deselected");
  a_hold_released: assert property (
    !spi_hold_n [*7] |-> !spi_miso_oe)
    else $error("data out driven while held");
  a_oe_follows_sel: assert property (
    spi_miso_oe |-> !$past(spi_cs_n, 3) || !$past(spi_cs_n, 4) || !$past(spi_cs_n, 5))
    else $error("data out enabled without a select");
  a_sel_active: assert property (
    !spi_cs_n [*5] |-> !standby)
    else $error("standby while selected");
  a_standby_idle: assert property (
    standby |-> !arr_wr_valid)
    else $error("standby while bytes are pending");
  a_op_one_cycle: assert property (
    arr_op_valid |=> !arr_op_valid)
    else $error("operation pulse longer than one cycle");
  a_byte_held: assert property (
    arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_addr) && $stable(arr_wr_data))
    else $error("staged byte changed before it was taken");
  a_burst_one_page: assert property (
    arr_wr_valid && arr_wr_ready && seen_q |-> arr_wr_addr[22:8] == page_q)
    else $error("burst left its page");

  c_op: cover property (arr_op_valid);
  c_stall: cover property (arr_wr_valid && !arr_wr_ready);
  c_hold: cover property (!spi_hold_n && !spi_cs_n);
endmodule : fls_target_checks

bind fls_spi_target fls_target_checks u_chk (
  .clock(clock), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_hold_n(spi_hold_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready), .arr_wr_addr(arr_wr_addr),
  .arr_wr_data(arr_wr_data), .arr_op_valid(arr_op_valid), .standby(standby)
);

`default_nettype wire

// ==== tb/fls_spi_master.sv ====
`timescale 1ns/100ps
`default_nettype none

// Behavioural bus master; the link clock moves only inside frames, apart from its first rise to the mode 3 park level.
module fls_spi_master (
  input  wire logic clock,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe,
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output var  logic spi_mosi,
  output var  logic spi_hold_n,
  output var  logic spi_wp_n
);
  logic mode3;  // Clock parks high when set.
  logic seen;   // Last level seen on the data line.
  // A released data line reads as the inverse of its last value.
  wire logic rx_line = spi_miso_oe ? spi_miso : ~seen;

  initial begin
    mode3 = 1'b0;
    seen = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    spi_hold_n = 1'b1;
    spi_wp_n = 1'b1;
  end

  // Half a link period of 160 ns.
  task half();
    repeat (8) @(negedge clock);
  endtask : half

  // Pause with the clock low, wiggle the ignored lines, then resume.
  task pause();
    half();
    spi_hold_n = 1'b0;
    half();
    spi_sclk = 1'b1;
    spi_mosi = ~spi_mosi;
    half();
    spi_sclk = 1'b0;
    half();
    spi_hold_n = 1'b1;
    half();
  endtask : pause

  // One frame: n bytes msb first, x extra bits, a pause before bit hb.
  task automatic frame(input int n, input logic [63:0] tx, input int x, input int hb,
                       output logic [7:0] rx);
    int i;
    rx = 8'h00;
    spi_sclk = mode3;
    half();
    spi_cs_n = 1'b0;
    half();
    for (i = 0; i < 8 * n + x; i++) begin
      spi_sclk = 1'b0;
      if (i == hb) begin
        pause();
      end
      spi_mosi = (i < 8 * n) ? tx[63-i] : 1'b1;
      half();
      seen = rx_line;
      rx = {rx[6:0], rx_line};
      spi_sclk = 1'b1;
      half();
    end
    // Mode 0 parks the clock low before the select rises.
    if (!mode3) begin
      spi_sclk = 1'b0;
      half();
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    half();
  endtask : frame
endmodule : fls_spi_master

`default_nettype wire

// ==== tb/serial_flash_spi_front_end_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fls_cfg.svh"

`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %s", $time, m); end end

module serial_flash_spi_front_end_test;
  logic        clock;
  logic        srst;
  wire logic   sclk, cs_n, mosi, hold_n, wp_n, miso, miso_oe;
  logic [22:0] rd_addr, wr_addr, op_addr;
  logic [7:0]  rd_data, wr_data;
  logic        wr_valid, op_valid, standby;
  logic [1:0]  op_code;
  logic [3:0]  tick;       // Drives a stalling ready.
  logic [30:0] wq[$];      // Bytes taken by the array.
  logic [24:0] oq[$];      // Operations seen.
  int          n_fail, n_checks;
  logic [7:0]  s;

  fls_spi_master m (.clock(clock), .spi_miso(miso), .spi_miso_oe(miso_oe), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_hold_n(hold_n), .spi_wp_n(wp_n));

  fls_spi_target #(.STATUS_US(1), .PAGE_US(4), .SECTOR_US(1), .BULK_US(1)) dut (
    .clock(clock), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_hold_n(hold_n), .spi_wp_n(wp_n), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .arr_rd_addr(rd_addr), .arr_rd_data(rd_data), .arr_wr_valid(wr_valid),
    .arr_wr_ready(tick[1]), .arr_wr_addr(wr_addr), .arr_wr_data(wr_data),
    .arr_op_valid(op_valid), .arr_op_code(op_code), .arr_op_addr(op_addr), .standby(standby));

  // Array reads answer combinationally with an address pattern.
  assign rd_data = rd_addr[7:0] ^ 8'h5a;

  initial clock = 1'b0;
  always #5 clock = ~clock;
  initial tick = 4'h0;
  // Ready stalls two cycles in four.
  always @(negedge clock) tick <= tick + 4'h1;

  // Record what the array side receives.
  always @(posedge clock) begin
    if (wr_valid && tick[1]) wq.push_back({wr_addr, wr_data});
    if (op_valid) oq.push_back({op_code, op_addr});
  end

  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic go(input int n, input logic [63:0] tx);
    logic [7:0] r;
    m.frame(n, tx, 0, -1, r);
  endtask : go

  task automatic rdsr();
    m.frame(2, {`FLS_STATUS_READ_CMD, 56'h0}, 0, -1, s);
  endtask : rdsr

  task automatic arm();
    go(1, {`FLS_ARM_WRITE_CMD, 56'h0});
  endtask : arm

  // Poll busy with a bound; running out ends the run.
  task automatic settle();
    int k;
    for (k = 0; k < 40 && !(s[0] === 1'b0 && k > 0); k++) rdsr();
    if (s[0] !== 1'b0) begin
      n_fail++;
      test_done();
    end
  endtask : settle

  task automatic status_write_cmd(input logic [7:0] v);
    arm();
    go(2, {`FLS_STATUS_WRITE_CMD, v, 48'h0});
    settle();
  endtask : status_write_cmd

  task automatic t_page();
    logic [30:0] e[3] = '{{23'h0000fe, 8'h11}, {23'h0000ff, 8'h22}, {23'h000000, 8'h33}};
    rdsr();
    `CHK(s, 8'h00, "status after reset")
    go(5, {`FLS_PAGE_WRITE_CMD, 24'h000100, 8'h44, 24'h0});
    rdsr();
    `CHK(oq[0][24:23], fls_pkg::OP_ABORT, "unarmed page write")
    `CHK(s[0], 1'b0, "unarmed page busy")
    oq.delete();
    wq.delete();
    arm();
    rdsr();
    `CHK(s, 8'h02, "latch after arm")
    go(7, {`FLS_PAGE_WRITE_CMD, 24'h0000fe, 24'h112233, 8'h0});
    `CHK(standby, 1'b0, "standby while busy")
    rdsr();
    `CHK(s[0], 1'b1, "busy during program")
    settle();
    `CHK(standby, 1'b1, "standby when idle")
    `CHK(s, 8'h00, "latch after program")
    foreach (e[i]) `CHK(wq[i], e[i], "staged byte")
    `CHK(oq[0][24:23], fls_pkg::OP_PROG, "program op")
  endtask : t_page

  task automatic t_wipe();
    logic [7:0] r;
    oq.delete();
    go(4, {`FLS_BLOCK_WIPE_CMD, 24'h010000, 32'h0});
    rdsr();
    `CHK(oq.size(), 0, "wipe without arm")
    arm();
    m.frame(4, {`FLS_BLOCK_WIPE_CMD, 24'h010000, 32'h0}, 3, -1, r);
    rdsr();
    `CHK(s[0], 1'b0, "ragged frame busy")
    `CHK(oq.size(), 0, "ragged frame op")
    arm();
    go(4, {`FLS_BLOCK_WIPE_CMD, 24'h010000, 32'h0});
    settle();
    `CHK(oq[0][24:16], {fls_pkg::OP_SECT, 7'h01}, "sector op")
  endtask : t_wipe

  // Levels 1 to 7: first protected sector refused, last open one, where any, wiped.
  task automatic t_prot();
    int lv, j, sec;
    for (lv = 1; lv < 8; lv++) begin
      status_write_cmd({3'h0, lv[2:0], 2'h0});
      `CHK(s, {3'h0, lv[2:0], 2'h0}, "level stored")
      for (j = 0; j < 2 && 128 - (1 << lv) - j >= 0; j++) begin
        sec = 128 - (1 << lv) - j;
        oq.delete();
        arm();
        go(4, {`FLS_BLOCK_WIPE_CMD, 1'b0, sec[6:0], 48'h0});
        settle();
        `CHK(oq.size() != 0 && oq[0][24:23] === fls_pkg::OP_SECT, j == 1, "protection")
      end
    end
    oq.delete();
    arm();
    go(1, {`FLS_CHIP_WIPE_CMD, 56'h0});
    settle();
    `CHK(oq.size(), 0, "chip wipe at level")
    status_write_cmd(8'h00);
    arm();
    go(1, {`FLS_CHIP_WIPE_CMD, 56'h0});
    settle();
    `CHK(oq[0][24:23], fls_pkg::OP_BULK, "chip wipe")
  endtask : t_prot

  task automatic t_lock();
    status_write_cmd(8'h88);
    m.spi_wp_n = 1'b0;
    status_write_cmd(8'h00);
    `CHK(s[7:2], 6'h22, "locked bits kept")
    m.spi_wp_n = 1'b1;
    status_write_cmd(8'h00);
    `CHK(s, 8'h00, "unlocked write")
  endtask : t_lock

  // Array read from a set address; the second byte shows the address steps.
  task automatic t_read();
    logic [7:0] r;
    m.frame(6, {`FLS_DATA_READ_CMD, 24'h000010, 32'h0}, 0, -1, r);
    `CHK(r, 8'h4b, "second read byte")
  endtask : t_read

  // Mode 3 with a pause in the middle of the reply byte.
  task automatic t_hold();
    m.mode3 = 1'b1;
    arm();
    m.frame(2, {`FLS_STATUS_READ_CMD, 56'h0}, 0, 11, s);
    `CHK(s, 8'h02, "reply across pause")
    go(1, {`FLS_DISARM_WRITE_CMD, 56'h0});
    rdsr();
    `CHK(s, 8'h00, "latch after disarm")
  endtask : t_hold

  initial begin
    srst = 1'b1;
    n_fail = 0;
    n_checks = 0;
    s = 8'h00;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    t_page();
    t_wipe();
    t_prot();
    t_lock();
    t_read();
    t_hold();
    test_done();
  end
endmodule : serial_flash_spi_front_end_test

`default_nettype wire
